/* File: rtl/fqr_reg_cmds.sv */
`timescale 1ns/1ps

module fqr_reg_cmds
    import fqr_pkg::*;
#(
    parameter int WR_TIME_NS = FQR_WR_TIME_NS
) (
    // core clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // serial link from the host controller
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [FQR_NPORT*FQR_LANES-1:0] io_in_i,
    output logic [FQR_NPORT*FQR_LANES-1:0] io_out_o,
    output logic [FQR_NPORT*FQR_LANES-1:0] io_oe_n_o,
    // mode and embedded-operation status from the rest of the die
    input wire logic quad_instruction_mode_i,
    input wire logic [FQR_NPORT-1:0][7:0] status_two_i,
    input wire logic [FQR_NPORT-1:0] program_fail_i,
    input wire logic [FQR_NPORT-1:0] erase_fail_i,
    // visible register state per quad port
    output fqr_regs_s [FQR_NPORT-1:0] regs_o
);

    // self-timed write length, a least time so rounded up
    localparam int WR_CYCLES_RAW =
        (WR_TIME_NS + FQR_CLK_PERIOD_NS - 1) / FQR_CLK_PERIOD_NS;
    localparam int WR_CYCLES = (WR_CYCLES_RAW < 1) ? 1 : WR_CYCLES_RAW;
    localparam logic [15:0] WR_LOAD = 16'(WR_CYCLES - 1);
    localparam int WR_BOUND = 1000;

    ////////////////////////////////////////////////////////////////////
    // shared link-side helpers

    // clears frame state while chip select is high or in reset
    logic link_clr;
    assign link_clr = cs_n_i | ~resetn_i;

    // mode level from the core domain, two flops on the link clock
    logic quad_s1;
    logic quad_s2;
    always_ff @(posedge sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quad_s1 <= 1'b0;
            quad_s2 <= 1'b0;
        end else begin
            quad_s1 <= quad_instruction_mode_i;
            quad_s2 <= quad_s1;
        end
    end

    // frame start flag, set by chip select, dropped at first edge
    logic first;
    always_ff @(posedge sck_i or posedge link_clr) begin
        if (link_clr) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared core-side helpers

    // chip select into the core clock; third flop only for the edge
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    // frame closed; link words are frozen since the clock has stopped
    logic frame_end;
    assign frame_end = cs_s2 & ~cs_s3;

    ////////////////////////////////////////////////////////////////////
    // one engine per quad port, each with its own registers

    for (genvar p = 0; p < FQR_NPORT; p++) begin : g_port

        // lane slice for this port
        logic [FQR_LANES-1:0] lane_in;
        assign lane_in = io_in_i[p*FQR_LANES +: FQR_LANES];

        // link: shift register, bit count, latched opcode
        logic [23:0] shreg;
        logic [5:0] bitcnt;
        logic [7:0] opcode;
        logic [23:0] base_sh;
        logic [5:0] base_cnt;
        logic [23:0] next_shreg;
        logic [5:0] next_bitcnt;

        // input assembly: one lane in single mode, four in quad
        always_comb begin
            base_sh = first ? 24'h000000 : shreg;
            base_cnt = first ? 6'h00 : bitcnt;
            if (quad_s2) begin
                next_shreg = {base_sh[19:0], lane_in};
                next_bitcnt = base_cnt + 6'h04;
            end else begin
                next_shreg = {base_sh[22:0], lane_in[0]};
                next_bitcnt = base_cnt + 6'h01;
            end
            // saturate so long frames cannot alias to a valid length
            if (base_cnt >= FQR_BITS_CAP) begin
                next_bitcnt = FQR_BITS_CAP;
            end
        end

        // sample on the rising link edge; not cleared by chip select
        // so the core can read the finished frame afterwards
        always_ff @(posedge sck_i or negedge resetn_i) begin
            if (!resetn_i) begin
                shreg <= 24'h000000;
                bitcnt <= 6'h00;
                opcode <= FQR_OP_NONE;
            end else begin
                shreg <= next_shreg;
                bitcnt <= next_bitcnt;
                if (next_bitcnt == FQR_BITS_OPCODE) begin
                    opcode <= next_shreg[7:0];
                end else if (first) begin
                    opcode <= FQR_OP_NONE;
                end
            end
        end

        // core -> link snapshot of readable bytes, req/ack handshake
        logic [23:0] snap;
        logic [23:0] live;
        logic req;
        logic ack;
        logic ack_s1;
        logic ack_s2;
        logic req_s1;
        logic req_s2;
        logic [23:0] lcopy;

        // link side: take the snapshot when a new request arrives
        always_ff @(posedge sck_i or negedge resetn_i) begin
            if (!resetn_i) begin
                req_s1 <= 1'b0;
                req_s2 <= 1'b0;
                ack <= 1'b0;
                lcopy <= {FQR_SR1_RESET, 8'h00, FQR_CR1_RESET};
            end else begin
                req_s1 <= req;
                req_s2 <= req_s1;
                if (req_s2 != ack) begin
                    lcopy <= snap;
                    ack <= req_s2;
                end
            end
        end

        // output byte chosen by opcode; quad mode serves status-1 only
        logic rd_en;
        logic [7:0] rd_byte;
        always_comb begin
            rd_byte = 8'h00;
            rd_en = 1'b0;
            if (opcode == FQR_OP_READ_STATUS_ONE) begin
                rd_byte = lcopy[23:16];
                rd_en = 1'b1;
            end else if (opcode == FQR_OP_READ_STATUS_TWO && !quad_s2) begin
                rd_byte = lcopy[15:8];
                rd_en = 1'b1;
            end else if (opcode == FQR_OP_READ_CONFIG_ONE && !quad_s2) begin
                rd_byte = lcopy[7:0];
                rd_en = 1'b1;
            end
            if (first || bitcnt < FQR_BITS_OPCODE) begin
                rd_en = 1'b0;
            end
        end

        // drive on the falling edge; reload at each byte boundary so
        // every byte below the 32-bit count cap (eight clocks single, two clocks quad) carries a fresh copy of the register
        logic [7:0] osh;
        logic [FQR_LANES-1:0] lane_out;
        logic [FQR_LANES-1:0] lane_oe_n;
        always_ff @(negedge sck_i or posedge link_clr) begin
            if (link_clr) begin
                osh <= 8'h00;
                lane_out <= 4'h0;
                lane_oe_n <= 4'hF;
            end else if (rd_en) begin
                if (quad_s2) begin
                    lane_oe_n <= 4'h0;
                    if (bitcnt[2:0] == 3'h0) begin
                        lane_out <= rd_byte[7:4];
                        osh <= {rd_byte[3:0], 4'h0};
                    end else begin
                        lane_out <= osh[7:4];
                        osh <= {osh[3:0], 4'h0};
                    end
                end else begin
                    lane_oe_n <= 4'hD;
                    if (bitcnt[2:0] == 3'h0) begin
                        lane_out <= {2'b00, rd_byte[7], 1'b0};
                        osh <= {rd_byte[6:0], 1'b0};
                    end else begin
                        lane_out <= {2'b00, osh[7], 1'b0};
                        osh <= {osh[6:0], 1'b0};
                    end
                end
            end else begin
                lane_out <= 4'h0;
                lane_oe_n <= 4'hF;
            end
        end
        assign io_out_o[p*FQR_LANES +: FQR_LANES] = lane_out;
        assign io_oe_n_o[p*FQR_LANES +: FQR_LANES] = lane_oe_n;

        // core: protect pin sampled by two flops
        logic wp_s1;
        logic wp_s2;
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                wp_s1 <= 1'b1;
                wp_s2 <= 1'b1;
            end else begin
                wp_s1 <= lane_in[2];
                wp_s2 <= wp_s1;
            end
        end

        // register file
        logic [7:0] volatile_status_one;
        logic [7:0] nonvolatile_status_one;
        logic [7:0] volatile_config_one;
        logic [7:0] nonvolatile_config_one;
        fqr_state_e state;
        logic [15:0] timer;
        logic [7:0] pend_sr;
        logic [7:0] pend_cr;
        logic pend_two;

        // hardware lock; the pin is a data lane when quad is set
        logic hw_lock;
        assign hw_lock = volatile_status_one[FQR_SR1_STATUS_WRITE_DISABLE_BIT] & ~wp_s2
                       & ~volatile_config_one[FQR_CR1_QUAD];

        // decoded frame
        logic is_write_enable_cmd;
        logic is_wrr;
        logic accept;
        assign is_write_enable_cmd = frame_end && opcode == FQR_OP_WRITE_ENABLE
                       && bitcnt == FQR_BITS_OPCODE;
        assign is_wrr = frame_end && opcode == FQR_OP_WRITE_REGISTERS
                      && (bitcnt == FQR_BITS_ONE_DATA
                      || bitcnt == FQR_BITS_TWO_DATA);
        // rejected silently when locked, or without the latch
        assign accept = is_wrr && volatile_status_one[FQR_SR1_WEL] && state == FQR_ST_IDLE
                      && !hw_lock;

        // write engine: idle, busy for the self-timed period, apply
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                state <= FQR_ST_IDLE;
                timer <= 16'h0000;
            end else begin
                case (state)
                    FQR_ST_IDLE: begin
                        if (accept) begin
                            state <= FQR_ST_BUSY;
                            timer <= WR_LOAD;
                        end
                    end
                    FQR_ST_BUSY: begin
                        if (timer == 16'h0000) begin
                            state <= FQR_ST_DONE;
                        end else begin
                            timer <= timer - 16'h0001;
                        end
                    end
                    default: begin
                        state <= FQR_ST_IDLE;
                    end
                endcase
            end
        end

        // pending data, caught at acceptance
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                pend_sr <= 8'h00;
                pend_cr <= 8'h00;
                pend_two <= 1'b0;
            end else if (accept) begin
                pend_two <= (bitcnt == FQR_BITS_TWO_DATA);
                if (bitcnt == FQR_BITS_TWO_DATA) begin
                    pend_sr <= shreg[15:8];
                    pend_cr <= shreg[7:0];
                end else begin
                    pend_sr <= shreg[7:0];
                    pend_cr <= nonvolatile_config_one;
                end
            end
        end

        // status-1 and config-1, volatile and nonvolatile
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                volatile_status_one <= FQR_SR1_RESET;
                nonvolatile_status_one <= FQR_SR1_RESET;
                volatile_config_one <= FQR_CR1_RESET;
                nonvolatile_config_one <= FQR_CR1_RESET;
            end else if (state == FQR_ST_DONE) begin
                volatile_status_one[FQR_SR1_WIP] <= 1'b0;
                volatile_status_one[FQR_SR1_WEL] <= 1'b0;
                if (program_fail_i[p] || erase_fail_i[p]) begin
                    // protect and config fields left as they were on a failed write; error flags set
                    volatile_status_one[FQR_SR1_P_ERR] <= volatile_status_one[FQR_SR1_P_ERR]
                                         | program_fail_i[p];
                    volatile_status_one[FQR_SR1_E_ERR] <= volatile_status_one[FQR_SR1_E_ERR]
                                         | erase_fail_i[p];
                end else begin
                    volatile_status_one[FQR_SR1_STATUS_WRITE_DISABLE_BIT] <= pend_sr[FQR_SR1_STATUS_WRITE_DISABLE_BIT];
                    nonvolatile_status_one[FQR_SR1_STATUS_WRITE_DISABLE_BIT] <= pend_sr[FQR_SR1_STATUS_WRITE_DISABLE_BIT];
                    // volatile copy always follows so protection
                    // takes effect at once
                    volatile_status_one[FQR_SR1_BP_HI:FQR_SR1_BP_LO]
                        <= pend_sr[FQR_SR1_BP_HI:FQR_SR1_BP_LO];
                    if (!nonvolatile_config_one[FQR_CR1_BP_DEST]) begin
                        nonvolatile_status_one[FQR_SR1_BP_HI:FQR_SR1_BP_LO]
                            <= pend_sr[FQR_SR1_BP_HI:FQR_SR1_BP_LO];
                    end
                    if (pend_two) begin
                        nonvolatile_config_one <= pend_cr;
                        volatile_config_one <= pend_cr;
                    end
                end
            end else if (accept) begin
                volatile_status_one[FQR_SR1_WIP] <= 1'b1;
            end else if (is_write_enable_cmd && state == FQR_ST_IDLE) begin
                volatile_status_one[FQR_SR1_WEL] <= 1'b1;
            end
        end

        // core side of the handshake; snapshot held while in flight
        assign live = {volatile_status_one, status_two_i[p], volatile_config_one};
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ack_s1 <= 1'b0;
                ack_s2 <= 1'b0;
                req <= 1'b0;
                snap <= {FQR_SR1_RESET, 8'h00, FQR_CR1_RESET};
            end else begin
                ack_s1 <= ack;
                ack_s2 <= ack_s1;
                if (req == ack_s2 && snap != live) begin
                    snap <= live;
                    req <= ~req;
                end
            end
        end

        assign regs_o[p] = '{status_one: volatile_status_one, config_one: volatile_config_one};

        // checks on the write path
        write_enable_cmd_sets_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            is_write_enable_cmd && state == FQR_ST_IDLE |=> volatile_status_one[FQR_SR1_WEL])
            else $error("write enable did not set latch");
        wip_starts_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            accept |=> volatile_status_one[FQR_SR1_WIP] && state == FQR_ST_BUSY)
            else $error("busy flag not raised on accepted write");
        wip_ends_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            $rose(volatile_status_one[FQR_SR1_WIP]) |-> ##[1:WR_BOUND]
                !volatile_status_one[FQR_SR1_WIP])
            else $error("register write did not complete in time");
        wel_clears_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            $fell(volatile_status_one[FQR_SR1_WIP]) |-> !volatile_status_one[FQR_SR1_WEL])
            else $error("latch still set after write");
        no_latch_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            is_wrr && !volatile_status_one[FQR_SR1_WEL] && state == FQR_ST_IDLE
            |=> $stable(volatile_status_one) && $stable(volatile_config_one) && state == FQR_ST_IDLE)
            else $error("write without latch changed state");
        hw_reject_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            is_wrr && hw_lock && state == FQR_ST_IDLE
            |=> !volatile_status_one[FQR_SR1_WIP]
                && $stable(volatile_status_one[FQR_SR1_E_ERR])
                && $stable(volatile_status_one[FQR_SR1_P_ERR]))
            else $error("locked write was not silently rejected");
        quad_unlock_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            volatile_config_one[FQR_CR1_QUAD] && is_wrr && volatile_status_one[FQR_SR1_WEL]
            && state == FQR_ST_IDLE |=> state == FQR_ST_BUSY)
            else $error("quad-mode write refused by the protect pin");
        fail_flag_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            state == FQR_ST_DONE && program_fail_i[p]
            |=> volatile_status_one[FQR_SR1_P_ERR] && $stable(volatile_config_one))
            else $error("program failure not flagged");
        bp_route_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            state == FQR_ST_DONE && nonvolatile_config_one[FQR_CR1_BP_DEST]
            && !program_fail_i[p] && !erase_fail_i[p]
            |=> $stable(nonvolatile_status_one[FQR_SR1_BP_HI:FQR_SR1_BP_LO]))
            else $error("volatile destination touched nv protect bits");
        quad_copy_a: assert property (@(posedge clock_i)
            disable iff (!resetn_i)
            state == FQR_ST_DONE && pend_two
            && !program_fail_i[p] && !erase_fail_i[p]
            |=> volatile_config_one[FQR_CR1_QUAD] == nonvolatile_config_one[FQR_CR1_QUAD])
            else $error("quad bit copies disagree after write");

        // main scenarios
        cov_one_byte_c: cover property (@(posedge clock_i)
            disable iff (!resetn_i)
            accept && bitcnt == FQR_BITS_ONE_DATA);
        cov_two_byte_c: cover property (@(posedge clock_i)
            disable iff (!resetn_i)
            accept && bitcnt == FQR_BITS_TWO_DATA);
        cov_locked_c: cover property (@(posedge clock_i)
            disable iff (!resetn_i)
            is_wrr && hw_lock && volatile_status_one[FQR_SR1_WEL]);
        cov_fail_c: cover property (@(posedge clock_i)
            disable iff (!resetn_i)
            state == FQR_ST_DONE && erase_fail_i[p]);
    end

endmodule

/* File: common/fqr_pkg.sv */
package fqr_pkg;

    // lanes per quad port, two quad ports side by side
    localparam int FQR_LANES = 4;
    localparam int FQR_NPORT = 2;

    // command opcodes
    localparam logic [7:0] FQR_OP_READ_STATUS_ONE = 8'h05;
    localparam logic [7:0] FQR_OP_READ_STATUS_TWO = 8'h07;
    localparam logic [7:0] FQR_OP_READ_CONFIG_ONE = 8'h35;
    localparam logic [7:0] FQR_OP_WRITE_REGISTERS = 8'h01;
    localparam logic [7:0] FQR_OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] FQR_OP_NONE = 8'hFF;

    // frame lengths in bits at chip-select rise
    localparam logic [5:0] FQR_BITS_OPCODE = 6'h08;
    localparam logic [5:0] FQR_BITS_ONE_DATA = 6'h10;
    localparam logic [5:0] FQR_BITS_TWO_DATA = 6'h18;
    localparam logic [5:0] FQR_BITS_CAP = 6'h20;

    // status-1 field positions
    localparam int FQR_SR1_WIP = 0;
    localparam int FQR_SR1_WEL = 1;
    localparam int FQR_SR1_BP_LO = 2;
    localparam int FQR_SR1_BP_HI = 4;
    localparam int FQR_SR1_E_ERR = 5;
    localparam int FQR_SR1_P_ERR = 6;
    localparam int FQR_SR1_STATUS_WRITE_DISABLE_BIT = 7;

    // config-1 field positions
    localparam int FQR_CR1_QUAD = 1;
    localparam int FQR_CR1_BP_DEST = 3;

    // reset values (delivery state)
    localparam logic [7:0] FQR_SR1_RESET = 8'h00;
    localparam logic [7:0] FQR_CR1_RESET = 8'h00;

    // timing: core clock period and self-timed register write
    localparam int FQR_CLK_PERIOD_NS = 10;
    localparam int FQR_WR_TIME_NS = 5000;

    // write engine states, gray along idle-busy-done
    typedef enum logic [1:0] {
        FQR_ST_IDLE = 2'b00,
        FQR_ST_BUSY = 2'b01,
        FQR_ST_DONE = 2'b11
    } fqr_state_e;

    // visible volatile register pair of one quad port
    typedef struct packed {
        logic [7:0] status_one;
        logic [7:0] config_one;
    } fqr_regs_s;

endpackage

/* File: test/fqr_host_model.sv */
`timescale 1ns/1ps

// host controller model: clock only runs inside frames
module fqr_host_model
    import fqr_pkg::*;
(
    // link toward the device
    output logic sck_o,
    output logic cs_n_o,
    output logic [7:0] io_o,
    // device lane drive
    input wire logic [7:0] dev_out_i,
    input wire logic [7:0] dev_oe_n_i
);
    logic [7:0] host_io = 8'h00; // lanes as the host drives them
    logic wp_n = 1'b1; // write-protect pin level
    logic q = 1'b0; // four lanes per edge
    logic [15:0] r0; // last two bytes seen on port 0
    logic [7:0] r1; // last byte seen on port 1
    initial sck_o = 1'b0;
    initial cs_n_o = 1'b1;
    // wire level: the device wins where it drives
    assign io_o = (dev_out_i & ~dev_oe_n_i) | (host_io & dev_oe_n_i);
    ////////////////////////////////////////////////////////////////////////
    // one frame, msb first; 80 ns period keeps well under the limit
    // in quad mode the bench reads only 05h, never 07h or 35h
    task frame(input logic [23:0] sh, input int nb);
        int i;
        #13 cs_n_o = 1'b0;
        for (i = 0; i < nb; i = i + (q ? 4 : 1)) begin
            // idle lanes toggle so a stale level never reads as data
            host_io = q ? {sh[23:20], sh[23:20]} : {~host_io[7], wp_n,
                ~host_io[5], sh[23], ~host_io[3], wp_n, ~host_io[1],
                sh[23]};
            sh = q ? sh << 4 : sh << 1;
            #40 sck_o = 1'b1;
            if (i >= 8) begin
                r0 = q ? {r0[11:0], io_o[3:0]} : {r0[14:0], io_o[1]};
                r1 = q ? {r1[3:0], io_o[7:4]} : {r1[6:0], io_o[5]};
            end
            #40 sck_o = 1'b0;
        end
        #40 cs_n_o = 1'b1; // select rises right after the last bit
        // the protect pin is a held level outside quad mode; every other lane toggles
        host_io = q ? ~host_io : {~host_io[7], wp_n, ~host_io[5:3], wp_n,
            ~host_io[1:0]};
        #200;
    endtask
endmodule

/* File: test/fqr_reg_cmds_bench.sv */
`timescale 1ns/1ps

// self-checking bench for the register command block
module fqr_reg_cmds_bench;
    import fqr_pkg::*;
    logic clock_i; // core clock
    logic resetn_i; // core reset
    logic sck; // link clock
    logic cs_n; // link select
    logic [7:0] io_in; // lane wire levels
    logic [7:0] io_out; // device lane data
    logic [7:0] io_oe_n; // device lane enables
    logic quad = 1'b0; // quad-instruction mode
    logic [1:0][7:0] st2 = {8'hA5, 8'h3C}; // status-2 per port
    logic [1:0] pfail = 2'b00; // program failure per port
    logic [1:0] efail = 2'b00; // erase failure per port
    fqr_regs_s [1:0] regs; // visible registers
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    fqr_reg_cmds #(.WR_TIME_NS(3000)) DUT (.clock_i(clock_i),
        .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n), .io_in_i(io_in),
        .io_out_o(io_out), .io_oe_n_o(io_oe_n),
        .quad_instruction_mode_i(quad), .status_two_i(st2),
        .program_fail_i(pfail), .erase_fail_i(efail), .regs_o(regs));
    fqr_host_model host (.sck_o(sck), .cs_n_o(cs_n), .io_o(io_in),
        .dev_out_i(io_out), .dev_oe_n_i(io_oe_n));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // hang guard, well above the expected run
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end
    task tally_and_finish();
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks_done = checks_done + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // write-enable first, then the write, then wait out the busy flag
    task wr(input logic [15:0] d, input int nb);
        int k;
        host.frame({FQR_OP_WRITE_ENABLE, 16'h0000}, 8);
        host.frame({FQR_OP_WRITE_REGISTERS, d}, nb); // reserved bits zero
        for (k = 0; k < 600 && regs[0].status_one[0] !== 1'b0; k++)
            @(posedge clock_i);
        repeat (5) @(posedge clock_i);
    endtask
    function automatic logic [15:0] st();
        return {regs[0].status_one, regs[1].status_one};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn_i = 1'b0;
        repeat (20) @(posedge clock_i);
        chk({regs[0]}, 16'h0000);
        chk({8'h00, io_oe_n}, 16'h00FF);
        resetn_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        host.frame({FQR_OP_READ_STATUS_ONE, 16'h0000}, 16);
        chk({host.r0[7:0], host.r1}, 16'h0000);
        // write without the latch is dropped
        host.frame({FQR_OP_WRITE_REGISTERS, 16'h9C00}, 16);
        chk(st(), 16'h0000);
        host.frame({FQR_OP_WRITE_ENABLE, 16'h0000}, 8);
        chk(st(), 16'h0202);
        // status read twice over while the write runs
        host.frame({FQR_OP_WRITE_REGISTERS, 16'h9C00}, 24);
        host.frame({FQR_OP_READ_STATUS_ONE, 16'h0000}, 24);
        chk(host.r0, 16'h0303);
        repeat (350) @(posedge clock_i);
        chk(st(), 16'h9C9C);
        host.frame({FQR_OP_READ_STATUS_TWO, 16'h0000}, 16);
        chk({host.r0[7:0], host.r1}, 16'h3CA5);
        // disable bit set and pin low: silent reject
        host.wp_n = 1'b0;
        wr(16'h0000, 16);
        chk(st(), 16'h9E9E);
        host.wp_n = 1'b1;
        wr(16'h8000, 16);
        chk(st(), 16'h8080);
        wr(16'h0000, 20);
        chk(st(), 16'h8282);
        wr(16'h800A, 24);
        chk({regs[0].status_one, regs[0].config_one}, 16'h800A);
        host.frame({FQR_OP_READ_CONFIG_ONE, 16'h0000}, 16);
        chk({host.r0[7:0], host.r1}, 16'h0A0A);
        // quad bit set: pin no longer protects
        host.wp_n = 1'b0;
        wr(16'h0000, 16);
        chk(st(), 16'h0000);
        pfail <= 2'b01;
        wr(16'h1C00, 16);
        chk(st(), 16'h401C);
        pfail <= 2'b00;
        efail <= 2'b10;
        quad <= 1'b1;
        repeat (10) @(posedge clock_i);
        // junk frame carries the mode level and the latest snapshot
        // across; its bit count never lands on a decoded length
        host.frame(24'hFFFFFF, 8);
        host.q = 1'b1;
        host.frame({FQR_OP_READ_STATUS_ONE, 16'h0000}, 16);
        chk({host.r0[7:0], host.r1}, 16'h401C);
        // quad write: port 0 lands, port 1 reports an erase failure
        wr(16'h0000, 16);
        chk(st(), 16'h403C);
        tally_and_finish();
    end
endmodule
